/* File: cal_pkg.sv */
package cal_pkg;
    // Register indices; byte address is four times the index
    localparam logic [7:0] IDX_CSI_ALARM_EN   = 8'h1C;
    localparam logic [7:0] IDX_SENSE_ALARM_EN = 8'h1D;
    localparam logic [7:0] IDX_BC_ALARM_EN    = 8'h1E;
    localparam logic [7:0] IDX_LANE_POL       = 8'h20;
    localparam logic [7:0] IDX_LP_POL         = 8'h21;
    localparam logic [7:0] IDX_HS_DBG         = 8'h22;
    localparam logic [7:0] IDX_LP_DBG         = 8'h23;
    localparam logic [7:0] IDX_TERM_DBG       = 8'h24;
    localparam logic [7:0] IDX_HDR_CTRL       = 8'h31;
    localparam logic [7:0] IDX_BC_CONFIG      = 8'h32;
    localparam logic [7:0] IDX_IRQ_STATUS     = 8'h40;
    localparam logic [7:0] IDX_IRQ_MASK       = 8'h41;
    localparam logic [7:0] IDX_HDR_VIEW       = 8'h42;
    localparam logic [7:0] IDX_SENSE_STATUS   = 8'h43;
    localparam logic [7:0] IDX_TEMP_THRESH    = 8'h44;
    localparam int unsigned IDX_LSB = 2;
    localparam int unsigned IDX_MSB = 9;

    // Reset values
    localparam logic [7:0] RST_CSI_ALARM_EN   = 8'h3F;
    localparam logic [7:0] RST_SENSE_ALARM_EN = 8'h00;
    localparam logic [7:0] RST_ZERO           = 8'h00;
    localparam logic [7:0] RST_HDR_CTRL       = 8'h20;
    localparam logic [7:0] RST_BC_CONFIG      = 8'h09;
    localparam logic [7:0] RST_TEMP_THRESH    = 8'h62;
    localparam logic [18:0] RST_IRQ           = 19'h0_0000;

    // Writable masks; other bits read zero
    localparam logic [7:0] WM_LANE_POL = 8'h1F;
    localparam logic [7:0] WM_DBG      = 8'h7F;

    // Field positions
    localparam int unsigned HDR_SEL_HI   = 7;
    localparam int unsigned HDR_SEL_LO   = 6;
    localparam int unsigned HDR_FIXED    = 5;
    localparam int unsigned HDR_PER_VC   = 4;
    localparam int unsigned TINIT_HI     = 2;
    localparam int unsigned LP_CLK_BIT   = 4;
    localparam int unsigned BC_PASS_ALL  = 7;
    localparam int unsigned BC_PASS_DEC  = 6;
    localparam int unsigned BC_AUTO_ACK  = 5;
    localparam int unsigned BC_PARITY    = 3;
    localparam int unsigned THR_HI_HI    = 6;
    localparam int unsigned THR_HI_LO    = 4;
    localparam int unsigned THR_LO_HI    = 2;

    // Interrupt status layout
    localparam int unsigned IRQ_CSI_LO   = 0;
    localparam int unsigned IRQ_SENSE_LO = 8;
    localparam int unsigned IRQ_BC_LO    = 16;
    localparam int unsigned IRQ_PARITY   = 18;
    localparam int unsigned IRQ_W        = 19;

    // Startup window timing
    localparam int unsigned CLK_HZ        = 10_000_000;
    localparam int unsigned TINIT_STEP_US = 100;
    localparam int unsigned TINIT_STEP_CYC = TINIT_STEP_US * (CLK_HZ / 1_000_000);

    typedef enum logic [1:0] {
        CAL_TM_COUNT = 2'b00,
        CAL_TM_DONE  = 2'b01
    } cal_tm_state_e;
endpackage

/* File: cal_tinit_timer.sv */
module cal_tinit_timer #(
    parameter int unsigned STEP_CYCLES = cal_pkg::TINIT_STEP_CYC
) (
    input  wire logic       clk,
    input  wire logic       rstn,
    input  wire logic [2:0] code,
    output logic            ignore
);
    initial begin
        if (STEP_CYCLES < 1 || STEP_CYCLES > 65535) begin
            $error("STEP_CYCLES out of range");
        end
    end

    cal_pkg::cal_tm_state_e state_q, state_d;
    logic [15:0] cyc_q, cyc_d;
    logic [2:0]  step_q, step_d;

    // Window is (code + 1) steps; code may move while counting
    always_comb begin
        state_d = state_q;
        cyc_d   = cyc_q;
        step_d  = step_q;
        if (state_q == cal_pkg::CAL_TM_COUNT) begin
            if (cyc_q == 16'(STEP_CYCLES - 1)) begin
                cyc_d = 16'h0000;
                if (step_q >= code) begin
                    state_d = cal_pkg::CAL_TM_DONE;
                end else begin
                    step_d = step_q + 3'd1;
                end
            end else begin
                cyc_d = cyc_q + 16'h0001;
            end
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            state_q <= cal_pkg::CAL_TM_COUNT;
            cyc_q   <= 16'h0000;
            step_q  <= 3'd0;
        end else begin
            state_q <= state_d;
            cyc_q   <= cyc_d;
            step_q  <= step_d;
        end
    end

    assign ignore = (state_q == cal_pkg::CAL_TM_COUNT);
endmodule

/* File: cal_regs.sv */
// Summary of operation
// - Enable bit 5 gates the no-frame-valid alarm; reset on.
// - Bits 4, 3 gate phy sync, phy control alarms; reset on.
// - Bits 2..0 gate ECC, checksum, length alarms; reset on.
// - Sense bits 5..0 gate temp and volt limit alarms; reset off.
// - Swap bits for data lanes 0-3 and clock lane; reset off.
// - Low-power inversion, clock bit 4, data bits 3:0; reset off.
// - Low-power control ignored (code+1) x 100 us after reset.
// - Select bit, reset one, shows corrected or raw header.
// - Capture bit stores headers per channel; select picks one.
// - Pass-all bit forwards every I2C transaction.
// - Decode bit forwards I2C transactions on address match.
// - Auto-ack bit acks every I2C write locally.
// - Parity checked while config bit 3 set; reset on.
// - Temperature above upper threshold sets over-temperature flag.
//
// The AHB-Lite slave port was chosen for this implementation.
module cal_regs #(
    parameter int unsigned TINIT_STEP_CYCLES = cal_pkg::TINIT_STEP_CYC
) (
    input  wire logic        clk,
    input  wire logic        rstn,
    // AHB-Lite slave
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic             hresp,
    output logic [31:0]      hrdata,
    output logic             irq,
    // Alarm conditions from pins
    input  wire logic [5:0]  csi_err_cond,
    input  wire logic [3:0]  volt_cond,
    input  wire logic [2:0]  temp_code,
    input  wire logic [1:0]  bc_cond,
    // Lane polarity and low-power control
    output logic [4:0]       lane_swap,
    input  wire logic [4:0]  lp_ctrl_in,
    output logic [4:0]       lp_ctrl_out,
    output logic             lp_ignore,
    // Header capture, same clock
    input  wire logic        hdr_valid,
    input  wire logic [1:0]  hdr_vc,
    input  wire logic [31:0] hdr_raw,
    input  wire logic [31:0] hdr_fixed,
    // I2C forwarding, same clock
    input  wire logic        i2c_start,
    input  wire logic        i2c_write,
    input  wire logic        i2c_addr_match,
    input  wire logic        fc_locked,
    input  wire logic        remote_ack,
    output logic             i2c_forward,
    output logic             i2c_local_ack,
    // Back-channel data, same clock
    input  wire logic        bc_valid,
    input  wire logic [7:0]  bc_data,
    input  wire logic        bc_parity
);
    initial begin
        if (TINIT_STEP_CYCLES < 1 || TINIT_STEP_CYCLES > 65535) begin
            $error("TINIT_STEP_CYCLES out of range");
        end
    end

    function automatic logic [7:0] idx_of(input logic [31:0] a);
        idx_of = a[cal_pkg::IDX_MSB:cal_pkg::IDX_LSB];
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Pin synchronisers
    logic [14:0] sync1_q, sync2_q;
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            sync1_q <= 15'h0000;
            sync2_q <= 15'h0000;
        end else begin
            sync1_q <= {csi_err_cond, volt_cond, temp_code, bc_cond};
            sync2_q <= sync1_q;
        end
    end
    logic [5:0] csi_c;
    logic [3:0] volt_c;
    logic [2:0] temp_c;
    logic [1:0] bc_c;
    assign {csi_c, volt_c, temp_c, bc_c} = sync2_q;
    // Lane control has its own pair; with the output register its pin-to-output latency is three cycles
    logic [4:0] lp1_q, lp2_q;
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            lp1_q <= 5'h00;
            lp2_q <= 5'h00;
        end else begin
            lp1_q <= lp_ctrl_in;
            lp2_q <= lp1_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // AHB address phase capture
    logic        wr_pend_q, wr_pend_d;
    logic [7:0]  wr_idx_q, wr_idx_d;
    logic [31:0] rdata_q, rdata_d;
    logic        take;
    assign take = hsel && hready && htrans[1];

    ////////////////////////////////////////////////////////////////////////////
    // Registers
    logic [7:0] csi_en_q, csi_en_d;
    logic [7:0] sense_en_q, sense_en_d;
    logic [7:0] bc_en_q, bc_en_d;
    logic [7:0] lane_pol_q, lane_pol_d;
    logic [7:0] lp_pol_q, lp_pol_d;
    logic [7:0] hs_dbg_q, hs_dbg_d;
    logic [7:0] lp_dbg_q, lp_dbg_d;
    logic [7:0] term_dbg_q, term_dbg_d;
    logic [7:0] hdr_ctrl_q, hdr_ctrl_d;
    logic [7:0] bc_cfg_q, bc_cfg_d;
    logic [7:0] thr_q, thr_d;
    logic [cal_pkg::IRQ_W-1:0] stat_q, stat_d;
    logic [cal_pkg::IRQ_W-1:0] mask_q, mask_d;
    logic [cal_pkg::IRQ_W-1:0] alarm;
    logic [5:0] sense_flags;
    logic       parity_err;
    logic       wr_now;
    assign wr_now = wr_pend_q;

    // Reading against the programmed threshold
    assign sense_flags = {temp_c > thr_q[cal_pkg::THR_HI_HI:cal_pkg::THR_HI_LO],
                          temp_c < thr_q[cal_pkg::THR_LO_HI:0],
                          volt_c};
    // Odd parity expected over data and parity bit
    assign parity_err = bc_valid && bc_cfg_q[cal_pkg::BC_PARITY]
                        && !(^{bc_data, bc_parity});

    always_comb begin
        alarm = '0;
        alarm[cal_pkg::IRQ_CSI_LO +: 6]   = csi_c & csi_en_q[5:0];
        alarm[cal_pkg::IRQ_SENSE_LO +: 6] = sense_flags & sense_en_q[5:0];
        alarm[cal_pkg::IRQ_BC_LO +: 2]    = bc_c & bc_en_q[1:0];
        alarm[cal_pkg::IRQ_PARITY]        = parity_err;
    end

    always_comb begin
        csi_en_d   = csi_en_q;
        sense_en_d = sense_en_q;
        bc_en_d    = bc_en_q;
        lane_pol_d = lane_pol_q;
        lp_pol_d   = lp_pol_q;
        hs_dbg_d   = hs_dbg_q;
        lp_dbg_d   = lp_dbg_q;
        term_dbg_d = term_dbg_q;
        hdr_ctrl_d = hdr_ctrl_q;
        bc_cfg_d   = bc_cfg_q;
        thr_d      = thr_q;
        mask_d     = mask_q;
        stat_d     = stat_q;
        if (wr_now) begin
            if (wr_idx_q == cal_pkg::IDX_CSI_ALARM_EN) begin
                csi_en_d = hwdata[7:0];
            end else if (wr_idx_q == cal_pkg::IDX_SENSE_ALARM_EN) begin
                sense_en_d = hwdata[7:0];
            end else if (wr_idx_q == cal_pkg::IDX_BC_ALARM_EN) begin
                bc_en_d = hwdata[7:0];
            end else if (wr_idx_q == cal_pkg::IDX_LANE_POL) begin
                lane_pol_d = hwdata[7:0] & cal_pkg::WM_LANE_POL;
            end else if (wr_idx_q == cal_pkg::IDX_LP_POL) begin
                lp_pol_d = hwdata[7:0];
            end else if (wr_idx_q == cal_pkg::IDX_HS_DBG) begin
                hs_dbg_d = hwdata[7:0] & cal_pkg::WM_DBG;
            end else if (wr_idx_q == cal_pkg::IDX_LP_DBG) begin
                lp_dbg_d = hwdata[7:0] & cal_pkg::WM_DBG;
            end else if (wr_idx_q == cal_pkg::IDX_TERM_DBG) begin
                term_dbg_d = hwdata[7:0];
            end else if (wr_idx_q == cal_pkg::IDX_HDR_CTRL) begin
                hdr_ctrl_d = hwdata[7:0];
            end else if (wr_idx_q == cal_pkg::IDX_BC_CONFIG) begin
                bc_cfg_d = hwdata[7:0];
            end else if (wr_idx_q == cal_pkg::IDX_TEMP_THRESH) begin
                thr_d = hwdata[7:0];
            end else if (wr_idx_q == cal_pkg::IDX_IRQ_MASK) begin
                mask_d = hwdata[cal_pkg::IRQ_W-1:0];
            end else if (wr_idx_q == cal_pkg::IDX_IRQ_STATUS) begin
                stat_d = stat_q & ~hwdata[cal_pkg::IRQ_W-1:0];
            end
        end
        // Set after clear so a same-cycle event is kept
        stat_d = stat_d | alarm;
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            csi_en_q   <= cal_pkg::RST_CSI_ALARM_EN;
            sense_en_q <= cal_pkg::RST_SENSE_ALARM_EN;
            bc_en_q    <= cal_pkg::RST_ZERO;
            lane_pol_q <= cal_pkg::RST_ZERO;
            lp_pol_q   <= cal_pkg::RST_ZERO;
            hs_dbg_q   <= cal_pkg::RST_ZERO;
            lp_dbg_q   <= cal_pkg::RST_ZERO;
            term_dbg_q <= cal_pkg::RST_ZERO;
            hdr_ctrl_q <= cal_pkg::RST_HDR_CTRL;
            bc_cfg_q   <= cal_pkg::RST_BC_CONFIG;
            thr_q      <= cal_pkg::RST_TEMP_THRESH;
            mask_q     <= cal_pkg::RST_IRQ;
            stat_q     <= cal_pkg::RST_IRQ;
        end else begin
            csi_en_q   <= csi_en_d;
            sense_en_q <= sense_en_d;
            bc_en_q    <= bc_en_d;
            lane_pol_q <= lane_pol_d;
            lp_pol_q   <= lp_pol_d;
            hs_dbg_q   <= hs_dbg_d;
            lp_dbg_q   <= lp_dbg_d;
            term_dbg_q <= term_dbg_d;
            hdr_ctrl_q <= hdr_ctrl_d;
            bc_cfg_q   <= bc_cfg_d;
            thr_q      <= thr_d;
            mask_q     <= mask_d;
            stat_q     <= stat_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Header capture
    logic [31:0] hraw_q [4];
    logic [31:0] hfix_q [4];
    logic [31:0] hraw_d [4];
    logic [31:0] hfix_d [4];
    logic [1:0]  wr_slot, rd_slot;
    logic [31:0] hdr_view;

    always_comb begin
        // Without per-channel capture every header lands in slot 0
        wr_slot = hdr_ctrl_q[cal_pkg::HDR_PER_VC] ? hdr_vc : 2'd0;
        rd_slot = hdr_ctrl_q[cal_pkg::HDR_PER_VC] ?
                  hdr_ctrl_q[cal_pkg::HDR_SEL_HI:cal_pkg::HDR_SEL_LO] : 2'd0;
        hraw_d = hraw_q;
        hfix_d = hfix_q;
        if (hdr_valid) begin
            hraw_d[wr_slot] = hdr_raw;
            hfix_d[wr_slot] = hdr_fixed;
        end
        hdr_view = hdr_ctrl_q[cal_pkg::HDR_FIXED] ? hfix_q[rd_slot] : hraw_q[rd_slot];
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            hraw_q <= '{default: 32'h0000_0000};
            hfix_q <= '{default: 32'h0000_0000};
        end else begin
            hraw_q <= hraw_d;
            hfix_q <= hfix_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Startup window and lane outputs
    logic       ign;
    logic [4:0] lp_out_d, lp_out_q;
    logic [4:0] swap_q;
    logic       ign_q;

    cal_tinit_timer #(
        .STEP_CYCLES (TINIT_STEP_CYCLES)
    ) u_tinit (
        .clk    (clk),
        .rstn   (rstn),
        .code   (hdr_ctrl_q[cal_pkg::TINIT_HI:0]),
        .ignore (ign)
    );

    always_comb begin
        // Held low while the startup window runs
        lp_out_d = ign ? 5'h00 : (lp2_q ^ lp_pol_q[cal_pkg::LP_CLK_BIT:0]);
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            lp_out_q <= 5'h00;
            swap_q   <= 5'h00;
            ign_q    <= 1'b1;
        end else begin
            lp_out_q <= lp_out_d;
            swap_q   <= lane_pol_q[4:0];
            ign_q    <= ign;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // I2C forwarding and acknowledge
    logic fwd_d, fwd_q, ack_d, ack_q;
    always_comb begin
        fwd_d = 1'b0;
        ack_d = 1'b0;
        if (i2c_start) begin
            fwd_d = bc_cfg_q[cal_pkg::BC_PASS_ALL]
                    || (bc_cfg_q[cal_pkg::BC_PASS_DEC] && i2c_addr_match);
            if (i2c_write) begin
                ack_d = bc_cfg_q[cal_pkg::BC_AUTO_ACK]
                        || (fc_locked && remote_ack);
            end else begin
                ack_d = fc_locked && remote_ack;
            end
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            fwd_q <= 1'b0;
            ack_q <= 1'b0;
        end else begin
            fwd_q <= fwd_d;
            ack_q <= ack_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Bus read mux and phase tracking
    logic irq_q;
    always_comb begin
        wr_pend_d = take && hwrite;
        wr_idx_d  = take ? idx_of(haddr) : wr_idx_q;
        rdata_d   = 32'h0000_0000;
        if (take && !hwrite) begin
            if (wr_idx_d == cal_pkg::IDX_CSI_ALARM_EN) begin
                rdata_d[7:0] = csi_en_q;
            end else if (wr_idx_d == cal_pkg::IDX_SENSE_ALARM_EN) begin
                rdata_d[7:0] = sense_en_q;
            end else if (wr_idx_d == cal_pkg::IDX_BC_ALARM_EN) begin
                rdata_d[7:0] = bc_en_q;
            end else if (wr_idx_d == cal_pkg::IDX_LANE_POL) begin
                rdata_d[7:0] = lane_pol_q;
            end else if (wr_idx_d == cal_pkg::IDX_LP_POL) begin
                rdata_d[7:0] = lp_pol_q;
            end else if (wr_idx_d == cal_pkg::IDX_HS_DBG) begin
                rdata_d[7:0] = hs_dbg_q;
            end else if (wr_idx_d == cal_pkg::IDX_LP_DBG) begin
                rdata_d[7:0] = lp_dbg_q;
            end else if (wr_idx_d == cal_pkg::IDX_TERM_DBG) begin
                rdata_d[7:0] = term_dbg_q;
            end else if (wr_idx_d == cal_pkg::IDX_HDR_CTRL) begin
                rdata_d[7:0] = hdr_ctrl_q;
            end else if (wr_idx_d == cal_pkg::IDX_BC_CONFIG) begin
                rdata_d[7:0] = bc_cfg_q;
            end else if (wr_idx_d == cal_pkg::IDX_TEMP_THRESH) begin
                rdata_d[7:0] = thr_q;
            end else if (wr_idx_d == cal_pkg::IDX_IRQ_STATUS) begin
                rdata_d[cal_pkg::IRQ_W-1:0] = stat_q;
            end else if (wr_idx_d == cal_pkg::IDX_IRQ_MASK) begin
                rdata_d[cal_pkg::IRQ_W-1:0] = mask_q;
            end else if (wr_idx_d == cal_pkg::IDX_HDR_VIEW) begin
                rdata_d = hdr_view;
            end else if (wr_idx_d == cal_pkg::IDX_SENSE_STATUS) begin
                rdata_d[6:0] = {ign, sense_flags};
            end
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            wr_pend_q <= 1'b0;
            wr_idx_q  <= 8'h00;
            rdata_q   <= 32'h0000_0000;
            irq_q     <= 1'b0;
        end else begin
            wr_pend_q <= wr_pend_d;
            wr_idx_q  <= wr_idx_d;
            rdata_q   <= rdata_d;
            irq_q     <= |(stat_d & mask_q);
        end
    end

    // Zero wait states; every access, mapped or not, answers OKAY
    logic rdy_q;
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            rdy_q <= 1'b1;
        end else begin
            rdy_q <= 1'b1;
        end
    end

    assign hreadyout     = rdy_q;
    assign hresp         = 1'b0;
    assign hrdata        = rdata_q;
    assign irq           = irq_q;
    assign lane_swap     = swap_q;
    assign lp_ctrl_out   = lp_out_q;
    assign lp_ignore     = ign_q;
    assign i2c_forward   = fwd_q;
    assign i2c_local_ack = ack_q;
endmodule

/* File: cal_regs_props.sv */
module cal_regs_props #(
    parameter int unsigned TINIT_STEP_CYCLES = cal_pkg::TINIT_STEP_CYC
) (
    input wire logic       clk,
    input wire logic       rstn,
    input wire logic       hsel,
    input wire logic [1:0] htrans,
    input wire logic       hwrite,
    input wire logic [4:0] lane_swap,
    input wire logic [4:0] lp_ctrl_out,
    input wire logic       lp_ignore,
    input wire logic       i2c_start,
    input wire logic       i2c_write,
    input wire logic       fc_locked,
    input wire logic       remote_ack,
    input wire logic       i2c_forward,
    input wire logic       i2c_local_ack
);
    // Saturates so a long run never wraps back into the window
    int unsigned cnt_q;
    logic        wr_req;
    assign wr_req = hsel && hwrite && htrans[1];
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            cnt_q <= 0;
        end else if (cnt_q < 1000) begin
            cnt_q <= cnt_q + 1;
        end
    end
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rstn);
    ////////////////////////////////////////////////////////////////////////
    win_min_a: assert property (cnt_q < TINIT_STEP_CYCLES |-> lp_ignore)
        else $error("window ended early");
    win_max_a: assert property (cnt_q > 8 * TINIT_STEP_CYCLES + 4 |-> !lp_ignore)
        else $error("window too long");
    win_once_a: assert property (!$rose(lp_ignore))
        else $error("window restarted");
    lp_hold_a: assert property (lp_ignore |-> lp_ctrl_out == 5'h00)
        else $error("low power control passed in window");
    swap_cause_a: assert property (!$stable(lane_swap) |-> $past(wr_req, 2) || $past(wr_req, 3))
        else $error("swap without write");
    fwd_idle_a: assert property (!i2c_start |=> !i2c_forward)
        else $error("forward without request");
    ack_cause_a: assert property (i2c_start && fc_locked && remote_ack |=> i2c_local_ack)
        else $error("remote ack not passed on");
    ack_read_a: assert property (i2c_start && !i2c_write && !(fc_locked && remote_ack) |=> !i2c_local_ack)
        else $error("read acked locally");
endmodule

bind cal_regs cal_regs_props #(.TINIT_STEP_CYCLES(TINIT_STEP_CYCLES)) u_props (
    .clk(clk), .rstn(rstn), .hsel(hsel), .htrans(htrans), .hwrite(hwrite), .lane_swap(lane_swap),
    .lp_ctrl_out(lp_ctrl_out), .lp_ignore(lp_ignore), .i2c_start(i2c_start), .i2c_write(i2c_write),
    .fc_locked(fc_locked), .remote_ack(remote_ack), .i2c_forward(i2c_forward), .i2c_local_ack(i2c_local_ack)
);

/* File: cal_far_end.sv */
module cal_far_end (
    input  wire logic       clk,
    input  wire logic       go_i2c,
    input  wire logic [3:0] kind,
    input  wire logic       go_bc,
    input  wire logic [7:0] byt,
    input  wire logic       bad,
    output logic            i2c_start,
    output logic [3:0]      i2c_lvl,
    output logic            bc_valid,
    output logic [7:0]      bc_data,
    output logic            bc_parity
);
    timeunit 1ns;
    timeprecision 1ns;
    initial {i2c_start, i2c_lvl, bc_valid, bc_data, bc_parity} = 15'h0000;
    // Released lines toggle so a stale level is never taken for a live one
    always @(posedge clk) begin
        i2c_start <= go_i2c;
        i2c_lvl <= go_i2c ? kind : ~i2c_lvl;
        bc_valid <= go_bc;
        bc_data <= go_bc ? byt : ~bc_data;
        bc_parity <= go_bc ? ~^byt ^ bad : ~bc_parity;
    end
endmodule

/* File: cal_regs_test.sv */
module cal_regs_test;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int unsigned STEP = 4;
    logic        clk = 1'b0;
    logic        rstn = 1'b0;
    logic        hsel = 1'b0;
    logic [31:0] haddr = 32'h0000_0000;
    logic [1:0]  htrans = 2'b00;
    logic        hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0000_0000;
    logic [5:0]  csi = 6'h00;
    logic [3:0]  volt = 4'h0;
    logic [2:0]  temp = 3'h4;
    logic [1:0]  bcc = 2'h0;
    logic [4:0]  lpi = 5'h00;
    logic        hv = 1'b0;
    logic [1:0]  hvc = 2'h0;
    logic [31:0] hraw = 32'h0000_0000;
    logic [31:0] hfix = 32'h0000_0000;
    logic        gi = 1'b0;
    logic        gb = 1'b0;
    logic        bad = 1'b0;
    logic [3:0]  kind = 4'h0;
    logic [7:0]  byt = 8'h00;
    logic        rdy, resp, irq, lpign, st, bv, bp, fwd, ack;
    logic [31:0] rdat, d, e, m;
    logic [4:0]  swap, lpo;
    logic [3:0]  lvl;
    logic [7:0]  bd;
    logic [17:0] en;
    int          n_errors = 0;
    int          n_compared = 0;
    int          sb;
    int          mdl[int];
    logic [7:0]  idx[13] = '{8'h1C, 8'h1D, 8'h1E, 8'h20, 8'h21, 8'h22, 8'h23, 8'h24, 8'h31, 8'h32, 8'h40, 8'h41, 8'h44};
    logic [7:0]  rv[13] = '{8'h3F, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h20, 8'h09, 8'h00, 8'h00, 8'h62};
    always #50 clk = ~clk;
    cal_regs #(.TINIT_STEP_CYCLES(STEP)) u_cal_regs (
        .clk(clk), .rstn(rstn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(3'h2), .hwdata(hwdata), .hready(rdy), .hreadyout(rdy), .hresp(resp), .hrdata(rdat),
        .irq(irq), .csi_err_cond(csi), .volt_cond(volt), .temp_code(temp), .bc_cond(bcc),
        .lane_swap(swap), .lp_ctrl_in(lpi), .lp_ctrl_out(lpo), .lp_ignore(lpign), .hdr_valid(hv),
        .hdr_vc(hvc), .hdr_raw(hraw), .hdr_fixed(hfix), .i2c_start(st), .i2c_write(lvl[3]),
        .i2c_addr_match(lvl[2]), .fc_locked(lvl[1]), .remote_ack(lvl[0]), .i2c_forward(fwd),
        .i2c_local_ack(ack), .bc_valid(bv), .bc_data(bd), .bc_parity(bp));
    cal_far_end u_cal_far_end (.clk(clk), .go_i2c(gi), .kind(kind), .go_bc(gb), .byt(byt), .bad(bad),
        .i2c_start(st), .i2c_lvl(lvl), .bc_valid(bv), .bc_data(bd), .bc_parity(bp));
    ////////////////////////////////////////////////////////////////////////
    task automatic test_done;
        if (n_errors == 0 && n_compared > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            n_errors++;
            $display("ERROR %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic wait_rdy;
        int n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (rdy !== 1'b1 && n < 20);
        if (rdy !== 1'b1) begin
            n_errors++;
            test_done;
        end
    endtask
    task automatic bus(input logic w, input logic [7:0] i, input logic [31:0] v);
        hsel <= 1'b1;
        htrans <= 2'b10;
        hwrite <= w;
        haddr <= {22'h00_0000, i, 2'b00};
        wait_rdy;
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= v;
        wait_rdy;
        d = rdat;
    endtask
    task automatic rd(input logic [7:0] i);
        bus(1'b0, i, 32'h0000_0000);
    endtask
    task automatic wr(input logic [7:0] i, input logic [7:0] v);
        bus(1'b1, i, {24'h00_0000, v});
        mdl[i] = i == 8'h20 ? v & 8'h1F : (i == 8'h22 || i == 8'h23) ? v & 8'h7F : v;
    endtask
    initial begin
        void'($urandom(32'hdc9e_5930));
        repeat (4) @(posedge clk);
        rstn <= 1'b1;
        lpi <= 5'h1F;
        @(negedge clk);
        chk("lp_ignore", 32'(lpign), 32'h0000_0001);
        chk("lp_out", 32'(lpo), 32'h0000_0000);
        @(posedge clk);
        foreach (idx[k]) begin
            mdl[idx[k]] = rv[k];
            rd(idx[k]);
            chk("reset value", d, 32'(rv[k]));
        end
        for (int k = 0; k < 10; k++) begin
            wr(idx[k], 8'($urandom));
            rd(idx[k]);
            chk("register", d, mdl[idx[k]]);
        end
        wr(8'h22, 8'h00);
        rd(8'h3F);
        chk("unmapped", d, 32'h0000_0000);
        chk("hresp", 32'(resp), 32'h0000_0000);
        chk("lane_swap", 32'(swap), mdl[8'h20]);
        lpi <= 5'($urandom);
        repeat (4) @(posedge clk);
        chk("lp_out", 32'(lpo), (32'(lpi) ^ mdl[8'h21]) & 32'h0000_001F);
        m = $urandom;
        bus(1'b1, 8'h41, m);
        en = {mdl[8'h1E][1:0], 2'b00, mdl[8'h1D][5:0], 2'b00, mdl[8'h1C][5:0]};
        for (int i = 0; i < 14; i++) begin
            sb = i < 6 ? i : i < 10 ? i + 2 : i == 10 ? 13 : i == 11 ? 12 : i + 4;
            csi <= i < 6 ? 6'h01 << i : 6'h00;
            volt <= (i > 5 && i < 10) ? 4'h1 << (i - 6) : 4'h0;
            temp <= i == 10 ? 3'h7 : i == 11 ? 3'h0 : 3'h4;
            bcc <= i > 11 ? 2'h1 << (i - 12) : 2'h0;
            repeat (6) @(posedge clk);
            {csi, volt, temp, bcc} <= 15'h0010;
            repeat (6) @(posedge clk);
            e = 32'(en[sb]) << sb;
            rd(8'h40);
            chk("status", d, e);
            chk("irq", 32'(irq), 32'(|(e & m)));
            bus(1'b1, 8'h40, 32'h0007_FFFF);
        end
        bus(1'b1, 8'h41, 32'h0004_0000);
        for (int c = 0; c < 16; c++) begin
            wr(8'h32, {c[3:1], 1'b0, c[0], 3'b001});
            {gi, gb} <= 2'b11;
            kind <= 4'($urandom);
            byt <= 8'($urandom);
            bad <= 1'($urandom);
            @(posedge clk);
            {gi, gb} <= 2'b00;
            @(posedge clk);
            @(negedge clk);
            chk("forward", 32'(fwd), 32'(c[3] | c[2] & kind[2]));
            chk("local_ack", 32'(ack), 32'(kind[3] & c[1] | kind[1] & kind[0]));
            @(posedge clk);
            rd(8'h40);
            chk("parity", d, 32'(bad & c[0]) << 18);
            bus(1'b1, 8'h40, 32'h0007_FFFF);
        end
        wr(8'h31, 8'h90);
        e = $urandom;
        hv <= 1'b1;
        hvc <= 2'h2;
        {hraw, hfix} <= {e, ~e};
        @(posedge clk);
        hvc <= 2'h1;
        {hraw, hfix} <= {~e, e};
        @(posedge clk);
        hv <= 1'b0;
        rd(8'h42);
        chk("header_raw", d, e);
        wr(8'h31, 8'hB0);
        rd(8'h42);
        chk("header_fixed", d, ~e);
        test_done;
    end
endmodule
